// ===== src/periph_port_timing.sv
// peripheral port cycle sequencer with its timing configuration register
`timescale 1ns/1ps
`default_nettype none

module periph_port_timing #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	// configuration register port
	input  wire logic [7:0]        cfg_index,
	input  wire logic              cfg_write,
	input  wire logic [7:0]        cfg_wdata,
	output logic      [7:0]        cfg_rdata,
	// pixel bus extension enable from the memory controls
	input  wire logic              pixel_bus16_en,
	// power-up straps
	input  wire logic              port_enable_strap_a,
	input  wire logic              port_enable_strap_b,
	input  wire logic              port_enable_strap_c,
	// request side
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [15:0]       req_wdata,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic      [15:0]       rsp_rdata,
	output logic                   port_enabled,
	// peripheral pins
	output logic      [ADDR_W-1:0] per_addr,
	output logic                   per_cs_n,
	output logic                   peripheral_read_strobe_n,
	output logic                   peripheral_write_strobe_n,
	output logic      [15:0]       per_data_out,
	output logic      [15:0]       per_data_oe,
	input  wire logic [15:0]       per_data_in,
	input  wire logic              ready_in,
	input  wire logic              data_acknowledge_in
);
	periph_port_pkg::cyc_state_t state_q;
	logic [7:0]        cfg_q, cfg_rdata_q, cyc_cfg_q;
	logic              cyc_wide_q, cyc_write_q, term_seen_q;
	logic [2:0]        cnt_q;
	logic [4:0]        sync1_q, sync2_q;
	logic              ack_old_q;
	logic [15:0]       data_s1_q, data_s2_q;
	logic [1:0]        strap_wait_q;
	logic              strap_done_q, port_en_q, req_ready_q, rsp_valid_q;
	logic [15:0]       rsp_rdata_q, data_out_q, data_oe_q;
	logic [ADDR_W-1:0] addr_q;
	logic              cs_n_q, rd_n_q, wr_n_q;
	logic              start, ready_s, ack_s, term_now, finish;
	logic [2:0]        addr_dly, sel_dly, rdy_dly, strb_min;
	logic [15:0]       lane_mask;

	// per-cycle timing picked from the copy taken at cycle start
	assign addr_dly  = cyc_cfg_q[periph_port_pkg::BIT_ADDR_DLY] ? periph_port_pkg::DLY_LONG
	                                                            : periph_port_pkg::DLY_SHORT;
	assign sel_dly   = cyc_cfg_q[periph_port_pkg::BIT_SEL_DLY] ? periph_port_pkg::DLY_LONG
	                                                           : periph_port_pkg::DLY_SHORT;
	assign rdy_dly   = cyc_cfg_q[periph_port_pkg::BIT_RDY_DLY] ? periph_port_pkg::DLY_LONG
	                                                           : periph_port_pkg::DLY_SHORT;
	assign strb_min  = cyc_cfg_q[periph_port_pkg::BIT_MIN_STRB] ? periph_port_pkg::STRB_MIN_LONG
	                                                            : periph_port_pkg::STRB_MIN_SHORT;
	assign lane_mask = cyc_wide_q ? periph_port_pkg::FULL_MASK : periph_port_pkg::LOW_BYTE_MASK;

	// termination detect and cycle end
	assign start    = req_valid && req_ready_q;
	assign ready_s  = sync2_q[0];
	assign ack_s    = sync2_q[1];
	assign term_now = cyc_cfg_q[periph_port_pkg::BIT_TERM] ? (ack_s && !ack_old_q)
	                                                       : (ready_s && (cnt_q >= rdy_dly));
	assign finish   = (state_q == periph_port_pkg::S_STROBE) && (term_seen_q || term_now)
	                  && (cnt_q >= strb_min);

	// two-flop synchronisers for ready, acknowledge, straps and data
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q   <= '0;
			sync2_q   <= '0;
			ack_old_q <= 1'b0;
			data_s1_q <= '0;
			data_s2_q <= '0;
		end else begin
			sync1_q   <= {port_enable_strap_c, port_enable_strap_b, port_enable_strap_a,
			              data_acknowledge_in, ready_in};
			sync2_q   <= sync1_q;
			ack_old_q <= sync2_q[1];
			data_s1_q <= per_data_in;
			data_s2_q <= data_s1_q;
		end
	end

	// strap capture once the synchronisers have settled after reset
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			strap_wait_q <= '0;
			strap_done_q <= 1'b0;
			port_en_q    <= 1'b0;
		end else if (!strap_done_q) begin
			if (strap_wait_q == periph_port_pkg::STRAP_SETTLE) begin
				strap_done_q <= 1'b1;
				port_en_q    <= (sync2_q[4:2] == periph_port_pkg::STRAP_ENABLE);
			end else begin
				strap_wait_q <= strap_wait_q + 2'h1;
			end
		end
	end

	// configuration register write and readback
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q       <= periph_port_pkg::CFG_RESET;
			cfg_rdata_q <= '0;
		end else begin
			if (cfg_write && cfg_index == periph_port_pkg::CFG_INDEX)
				cfg_q <= cfg_wdata & periph_port_pkg::CFG_WMASK;
			cfg_rdata_q <= (cfg_index == periph_port_pkg::CFG_INDEX) ? cfg_q : '0;
		end
	end

	// request handshake
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			req_ready_q <= 1'b0;
		end else if (start || state_q != periph_port_pkg::S_IDLE) begin
			req_ready_q <= 1'b0;
		end else begin
			req_ready_q <= port_en_q;
		end
	end

	// cycle sequencer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q     <= periph_port_pkg::S_IDLE;
			cnt_q       <= '0;
			term_seen_q <= 1'b0;
			cyc_cfg_q   <= periph_port_pkg::CFG_RESET;
			cyc_wide_q  <= 1'b0;
			cyc_write_q <= 1'b0;
		end else begin
			unique case (state_q)
				periph_port_pkg::S_IDLE: begin
					term_seen_q <= 1'b0;
					if (start) begin
						state_q     <= periph_port_pkg::S_ADDR;
						cnt_q       <= periph_port_pkg::DLY_SHORT;
						cyc_cfg_q   <= cfg_q;
						cyc_wide_q  <= cfg_q[periph_port_pkg::BIT_WIDE] && !pixel_bus16_en;
						cyc_write_q <= req_write;
					end
				end
				periph_port_pkg::S_ADDR: begin
					if (cnt_q == addr_dly) begin
						state_q <= periph_port_pkg::S_SEL;
						cnt_q   <= periph_port_pkg::DLY_SHORT;
					end else begin
						cnt_q <= cnt_q + 3'h1;
					end
				end
				periph_port_pkg::S_SEL: begin
					if (cnt_q == sel_dly) begin
						state_q <= periph_port_pkg::S_STROBE;
						cnt_q   <= periph_port_pkg::DLY_SHORT;
					end else begin
						cnt_q <= cnt_q + 3'h1;
					end
				end
				periph_port_pkg::S_STROBE: begin
					if (term_now)
						term_seen_q <= 1'b1;
					if (finish)
						state_q <= periph_port_pkg::S_IDLE;
					if (cnt_q != periph_port_pkg::CNT_MAX)
						cnt_q <= cnt_q + 3'h1;
				end
			endcase
		end
	end

	// pin drivers: address, select, strobes and write data
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			addr_q     <= '0;
			cs_n_q     <= 1'b1;
			rd_n_q     <= 1'b1;
			wr_n_q     <= 1'b1;
			data_out_q <= '0;
			data_oe_q  <= '0;
		end else begin
			if (start) begin
				addr_q     <= req_addr;
				data_out_q <= req_wdata;
			end
			if (state_q == periph_port_pkg::S_ADDR && cnt_q == addr_dly)
				cs_n_q <= 1'b0;
			if (state_q == periph_port_pkg::S_SEL && cnt_q == sel_dly) begin
				rd_n_q <= cyc_write_q;
				wr_n_q <= !cyc_write_q;
			end
			if (finish) begin
				cs_n_q <= 1'b1;
				rd_n_q <= 1'b1;
				wr_n_q <= 1'b1;
			end
			if (state_q == periph_port_pkg::S_ADDR && cyc_write_q)
				data_oe_q <= lane_mask;
			else if (finish || state_q == periph_port_pkg::S_IDLE)
				data_oe_q <= '0;
		end
	end

	// response capture at cycle end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rsp_valid_q <= 1'b0;
			rsp_rdata_q <= '0;
		end else begin
			rsp_valid_q <= finish;
			if (finish && !cyc_write_q)
				rsp_rdata_q <= data_s2_q & lane_mask;
		end
	end

	assign cfg_rdata                 = cfg_rdata_q;
	assign req_ready                 = req_ready_q;
	assign rsp_valid                 = rsp_valid_q;
	assign rsp_rdata                 = rsp_rdata_q;
	assign port_enabled              = port_en_q;
	assign per_addr                  = addr_q;
	assign per_cs_n                  = cs_n_q;
	assign peripheral_read_strobe_n  = rd_n_q;
	assign peripheral_write_strobe_n = wr_n_q;
	assign per_data_out              = data_out_q;
	assign per_data_oe               = data_oe_q;

	// checks on the generated cycle timing
	localparam int BUS_HI = periph_port_pkg::BUS_W - 1;
	logic strb_n;
	assign strb_n = rd_n_q && wr_n_q;

	select_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		start && !cfg_q[periph_port_pkg::BIT_ADDR_DLY] |=> cs_n_q ##1 !cs_n_q)
		else $error("select not one clock after address");
	select_delay_long_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		start && cfg_q[periph_port_pkg::BIT_ADDR_DLY] |=> cs_n_q[*2] ##1 !cs_n_q)
		else $error("select not two clocks after address");
	strobe_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(cs_n_q) && !cyc_cfg_q[periph_port_pkg::BIT_SEL_DLY] |-> strb_n ##1 !strb_n)
		else $error("strobe not one clock after select");
	strobe_delay_long_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(cs_n_q) && cyc_cfg_q[periph_port_pkg::BIT_SEL_DLY] |-> strb_n[*2] ##1 !strb_n)
		else $error("strobe not two clocks after select");
	strobe_width_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(strb_n) && !cyc_cfg_q[periph_port_pkg::BIT_MIN_STRB] |-> !strb_n[*2])
		else $error("strobe shorter than two clocks");
	strobe_width_long_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(strb_n) && cyc_cfg_q[periph_port_pkg::BIT_MIN_STRB] |-> !strb_n[*4])
		else $error("strobe shorter than four clocks");
	ready_sample_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(strb_n) && !cyc_cfg_q[periph_port_pkg::BIT_TERM]
		&& cyc_cfg_q[periph_port_pkg::BIT_RDY_DLY] |-> !term_now)
		else $error("ready sampled before the set delay");
	end_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(strb_n) |-> $rose(cs_n_q) && $past(term_seen_q || term_now))
		else $error("cycle ended without termination");
	lane_width_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!cyc_wide_q |-> data_oe_q[BUS_HI:periph_port_pkg::BYTE_W] == '0)
		else $error("upper byte driven on narrow bus");
	pixel_conflict_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		start && pixel_bus16_en |=> !cyc_wide_q)
		else $error("wide port used with pixel bus");
	port_disabled_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		strap_done_q && !port_en_q |-> cs_n_q && !req_ready_q)
		else $error("disabled port ran a cycle");

	write_cycle_c: cover property (@(posedge clk_sys) disable iff (!rst_b) start && req_write ##[1:40] rsp_valid_q);
	read_cycle_c: cover property (@(posedge clk_sys) disable iff (!rst_b) start && !req_write ##[1:40] rsp_valid_q);
	ack_end_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
		cyc_cfg_q[periph_port_pkg::BIT_TERM] && finish);
endmodule : periph_port_timing

`default_nettype wire

// ===== src/periph_port_pkg.sv
// constants for the peripheral port timing block
package periph_port_pkg;
	// configuration register index and layout
	localparam logic [7:0] CFG_INDEX     = 8'h19;
	localparam logic [7:0] CFG_RESET     = 8'h00;
	localparam logic [7:0] CFG_WMASK     = 8'h3F; // bits 7:6 reserved, read as zero
	localparam int         BIT_WIDE      = 0;     // 16-bit data bus
	localparam int         BIT_TERM      = 1;     // terminate on acknowledge edge
	localparam int         BIT_ADDR_DLY  = 2;     // address to select delay
	localparam int         BIT_RDY_DLY   = 3;     // strobe to first ready sample
	localparam int         BIT_SEL_DLY   = 4;     // select to strobe delay
	localparam int         BIT_MIN_STRB  = 5;     // minimum strobe width
	// delays in clocks
	localparam logic [2:0] DLY_SHORT     = 3'h1;
	localparam logic [2:0] DLY_LONG      = 3'h2;
	localparam logic [2:0] STRB_MIN_SHORT = 3'h2;
	localparam logic [2:0] STRB_MIN_LONG  = 3'h4;
	localparam logic [2:0] CNT_MAX       = 3'h7;
	// power-up straps
	localparam logic [2:0] STRAP_ENABLE  = 3'h7;
	localparam logic [1:0] STRAP_SETTLE  = 2'h2;
	// bus widths
	localparam int         BUS_W         = 16;
	localparam int         BYTE_W        = 8;
	localparam logic [15:0] LOW_BYTE_MASK = 16'h00FF;
	localparam logic [15:0] FULL_MASK     = 16'hFFFF;

	typedef enum logic [1:0] {
		S_IDLE   = 2'b00,
		S_ADDR   = 2'b01,
		S_SEL    = 2'b10,
		S_STROBE = 2'b11
	} cyc_state_t;
endpackage : periph_port_pkg

// ===== verification/periph_model.sv
// behavioural peripheral on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module periph_model (
	// clock
	input  wire logic        clk_sys,
	// behaviour chosen by the bench
	input  wire logic        ack_mode,
	input  wire logic [1:0]  wait_n,
	// port pins
	input  wire logic [15:0] per_addr,
	input  wire logic        per_cs_n,
	input  wire logic        peripheral_read_strobe_n,
	input  wire logic        peripheral_write_strobe_n,
	input  wire logic [15:0] per_data_out,
	input  wire logic [15:0] per_data_oe,
	output logic      [15:0] per_data_in,
	output logic             ready_in,
	output logic             data_acknowledge_in
);
	logic [15:0] mem [256];
	int          cnt;
	logic        act;

	// a cycle is live while select and either strobe are low
	assign act = !per_cs_n && !(peripheral_read_strobe_n && peripheral_write_strobe_n);

	initial begin
		cnt = 0;
		per_data_in = 16'h0000;
		ready_in = 1'b0;
		data_acknowledge_in = 1'b0;
	end

	// answer after wait_n clocks, hold until the strobe goes away
	always @(posedge clk_sys) begin
		cnt <= act ? cnt + 1 : 0;
		ready_in <= act && !ack_mode && cnt >= int'(wait_n);
		data_acknowledge_in <= act && ack_mode && cnt >= int'(wait_n);
		if (act && !peripheral_write_strobe_n)
			mem[per_addr[7:0]] <= per_data_out & per_data_oe;
		// a released bus toggles so stale data never looks valid
		per_data_in <= (act && !peripheral_read_strobe_n) ? mem[per_addr[7:0]] : ~per_data_in;
	end
endmodule : periph_model
`default_nettype wire

// ===== verification/test_general_purpose_io_bus_timing.sv
// self-checking bench for the peripheral port timing block
`timescale 1ns/1ps
`default_nettype none
module test_general_purpose_io_bus_timing;
	logic clk_sys = 0, rst_b = 0, cfg_write = 0, pix = 0, req_valid = 0, req_write = 0, ack_mode = 0;
	logic [7:0] cfg_index = 0, cfg_wdata = 0, cfg_rdata;
	logic [2:0] straps = 3'h3;
	logic [15:0] req_addr = 0, req_wdata = 0, rsp_rdata, per_addr, per_data_out, per_data_oe, per_data_in;
	logic req_ready, rsp_valid, port_enabled, per_cs_n, rd_n, wr_n, ready_in, ack_in;
	logic [1:0] wait_n = 0;
	logic [15:0] mref [256];
	logic [31:0] rs = 32'h58fd_fcb7;
	int n_errors = 0, compares = 0;

	// 10 MHz clock
	always #50 clk_sys = ~clk_sys;

	periph_port_timing dut (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_index(cfg_index), .cfg_write(cfg_write),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .pixel_bus16_en(pix), .port_enable_strap_a(straps[0]),
		.port_enable_strap_b(straps[1]), .port_enable_strap_c(straps[2]), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .port_enabled(port_enabled), .per_addr(per_addr),
		.per_cs_n(per_cs_n), .peripheral_read_strobe_n(rd_n), .peripheral_write_strobe_n(wr_n),
		.per_data_out(per_data_out), .per_data_oe(per_data_oe), .per_data_in(per_data_in),
		.ready_in(ready_in), .data_acknowledge_in(ack_in));

	periph_model peer (.clk_sys(clk_sys), .ack_mode(ack_mode), .wait_n(wait_n), .per_addr(per_addr),
		.per_cs_n(per_cs_n), .peripheral_read_strobe_n(rd_n), .peripheral_write_strobe_n(wr_n),
		.per_data_out(per_data_out), .per_data_oe(per_data_oe), .per_data_in(per_data_in),
		.ready_in(ready_in), .data_acknowledge_in(ack_in));

	// verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// value comparison
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// cycle count comparison against a range; a spent wait ends the run
	task automatic chk_cnt(input string n, input int lo, input int hi, input int g);
		compares++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("wrong value %s expected %0d seen %0d", n, lo, g);
		end
		if (g >= 40)
			end_of_test();
	endtask : chk_cnt

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// reset for 8 clocks with the given straps
	task automatic do_reset(input logic [2:0] s);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		straps <= s;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
	endtask : do_reset

	task automatic cfg_wr(input logic [7:0] v);
		@(posedge clk_sys);
		cfg_index <= 8'h19;
		cfg_write <= 1'b1;
		cfg_wdata <= v;
		@(posedge clk_sys);
		cfg_write <= 1'b0;
	endtask : cfg_wr

	task automatic cfg_rd(input logic [7:0] i, input logic [7:0] e);
		@(posedge clk_sys);
		cfg_index <= i;
		repeat (2) @(posedge clk_sys);
		#1 chk("config readback", {8'h00, e}, {8'h00, cfg_rdata});
	endtask : cfg_rd

	// one port cycle, timed and checked against the model
	task automatic op(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
		int k;
		logic [15:0] m;
		m = (c[0] && !pix) ? 16'hffff : 16'h00ff;
		k = 0;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= a;
		req_wdata <= d;
		do begin
			@(posedge clk_sys);
			k++;
		end while (req_ready !== 1'b1 && k < 40);
		req_valid <= 1'b0;
		chk_cnt("accept wait", 0, 39, k);
		k = 0;
		#1;
		while (per_cs_n !== 1'b0 && k < 40) begin
			@(posedge clk_sys);
			#1 k++;
		end
		chk_cnt("select delay", c[2] ? 2 : 1, c[2] ? 2 : 1, k);
		k = 0;
		while ((wr ? wr_n : rd_n) !== 1'b0 && k < 40) begin
			@(posedge clk_sys);
			#1 k++;
		end
		chk_cnt("strobe delay", c[4] ? 2 : 1, c[4] ? 2 : 1, k);
		chk("address", a, per_addr);
		if (wr) begin
			mref[a[7:0]] = d & m;
			chk("write data", d & m, per_data_out & per_data_oe);
		end
		k = 0;
		while ((wr ? wr_n : rd_n) === 1'b0 && k < 40) begin
			@(posedge clk_sys);
			#1 k++;
		end
		chk_cnt("strobe width", c[5] ? 4 : 2, 12, k);
		chk("end of cycle", 16'h0003, {14'h0, rsp_valid, per_cs_n});
		if (!wr)
			chk("read data", mref[a[7:0]] & m, rsp_rdata);
	endtask : op

	// main sequence
	initial begin
		do_reset(3'h3);
		chk("port off", 16'h0000, {14'h0, port_enabled, req_ready});
		do_reset(3'h7);
		chk("port on", 16'h0003, {14'h0, port_enabled, req_ready});
		cfg_wr(8'hff);
		cfg_rd(8'h19, 8'h3f);
		cfg_rd(8'h18, 8'h00);
		$display("config test done");
		for (int c = 0; c < 64; c++) begin
			rs = xs(rs);
			pix <= rs[0] & rs[1];
			wait_n <= rs[3:2];
			ack_mode <= c[1];
			cfg_wr(8'(c));
			op(1'b1, rs[31:16], rs[15:0], 8'(c));
			op(1'b0, rs[31:16], 16'h0000, 8'(c));
		end
		$display("cycle test done");
		end_of_test();
	end
endmodule : test_general_purpose_io_bus_timing
`default_nettype wire
